// ===== src/uiop_reg.sv
// Behaviour
// R1 - three aliases read; write, set, clear
// R2 - set/clear alias touch only one bits
// R3 - swap bit exchanges plus/minus pins, resets zero
// R4 - in uart mode swap exchanges tx/rx routing
// R5 - audio speaker routing ignores swap
// R6 - usb to uart entry with transmit enable applies uart level
// R7 - audio mode forces 3.3 volt regulator
// R8 - link should leave uart via hardware reset
// R9 - bits 4/5 enable plus/minus charger pull-ups
// R10 - uart mode forces both pull-ups on
// R11 - usb modes use usb level, reset 00
`timescale 1ns/100ps
`default_nettype none
`include "uiop_defs.svh"

module uiop_reg
  import uiop_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire uiop_req_t   req,
  output logic [7:0]       rdata,
  input  wire uiop_mode_t  mode,
  input  wire logic        uart_transmit_enable,
  output uiop_ctrl_t       ctrl,
  output logic [1:0]       data_plus_function,
  output logic [1:0]       data_minus_function
);
  import uiop_pkg::*;

  // writable bits; bit 0 is reserved and always reads back zero
  localparam logic [7:0] WRITE_MASK = `UIOP_WRITE_MASK;

  // control register and its next value
  logic [7:0] ctl;
  logic [7:0] next_ctl;

  // read path
  logic [7:0] next_rdata;

  // alias decode, one strobe per alias
  logic       wr_base;
  logic       wr_set;
  logic       wr_clear;
  logic       hit;

  // mode history for the automatic uart level
  uiop_mode_t prev_mode;
  uiop_mode_t next_prev_mode;
  logic       from_usb;
  logic       next_from_usb;
  logic       uart_level_on;
  logic       next_uart_level_on;

  // analog controls
  uiop_ctrl_t next_ctrl;
  logic [1:0] route_plus;
  logic [1:0] route_minus;

  // R1 alias decode
  // the strobes are one-hot by construction, so the per-bit logic below
  // never has to arbitrate between a plain write and a set or clear
  always_comb
  begin
    wr_base  = 1'b0;
    wr_set   = 1'b0;
    wr_clear = 1'b0;
    hit      = 1'b0;
    case (req.addr)
      `UIOP_ADDR_BASE:
      begin
        wr_base = req.wr;
        hit     = 1'b1;
      end
      `UIOP_ADDR_SET:
      begin
        wr_set = req.wr;
        hit    = 1'b1;
      end
      `UIOP_ADDR_CLEAR:
      begin
        wr_clear = req.wr;
        hit      = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // R2 per-bit write, set and clear
  // each bit only looks at its own data bit, so a set or clear leaves
  // every bit whose data bit is zero exactly as it was
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      always_comb
      begin
        next_ctl[b] = ctl[b];
        if (!WRITE_MASK[b])
          next_ctl[b] = 1'b0;
        else if (wr_base)
          next_ctl[b] = req.wdata[b];
        else if (wr_set && req.wdata[b])
          next_ctl[b] = 1'b1;
        else if (wr_clear && req.wdata[b])
          next_ctl[b] = 1'b0;
      end
    end
  endgenerate

  // control register
  always_ff @(posedge clk)
  begin
    if (rst)
      ctl <= `UIOP_RESET_VAL;
    else
      ctl <= next_ctl;
  end

  // R1 any alias reads; unmapped reads zero
  // a read sees the register before a write in the same cycle, but the
  // master never issues both strobes at once
  always_comb
  begin
    next_rdata = 8'h00;
    if (req.rd && hit)
      next_rdata = ctl;
  end

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  // R6 uart level applies once transmit enable rises after a usb to uart
  // switch; transmit enable may come in the same cycle as the switch or
  // any time later while uart mode lasts. leaving uart drops it again,
  // which the link should do by hard reset (R8). mode and transmit enable
  // come from this clock domain, so no synchroniser
  always_comb
  begin
    next_prev_mode     = mode;
    next_from_usb      = 1'b0;
    next_uart_level_on = 1'b0;
    if (mode == UIOP_MODE_UART)
    begin
      next_from_usb      = from_usb || (prev_mode == UIOP_MODE_USB);
      next_uart_level_on = uart_level_on || (uart_transmit_enable && next_from_usb);
    end
  end

  // mode history; reset counts as usb so a uart start after reset applies
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_mode     <= UIOP_MODE_USB;
      from_usb      <= 1'b0;
      uart_level_on <= 1'b0;
    end
    else
    begin
      prev_mode     <= next_prev_mode;
      from_usb      <= next_from_usb;
      uart_level_on <= next_uart_level_on;
    end
  end

  // R3 R4 pad routing; swap exchanges which pad gets which function
  uiop_route u_route
  (
    .mode        (mode),
    .swap        (ctl[`UIOP_BIT_SWAP]),
    .plus_route  (route_plus),
    .minus_route (route_minus)
  );

  // analog controls
  always_comb
  begin
    next_ctrl               = '0;
    next_ctrl.data_pin_swap = ctl[`UIOP_BIT_SWAP];
    // R9 pull-up enables
    next_ctrl.pullup_plus   = ctl[`UIOP_BIT_PU_PLUS];
    next_ctrl.pullup_minus  = ctl[`UIOP_BIT_PU_MIN];
    // R11 usb level by default
    next_ctrl.regulator_level = ctl[`UIOP_USB_HI:`UIOP_USB_LO];
    next_ctrl.plus_route    = route_plus;
    next_ctrl.minus_route   = route_minus;
    case (mode)
      UIOP_MODE_UART:
      begin
        // R10 pull-ups forced
        next_ctrl.pullup_plus  = 1'b1;
        next_ctrl.pullup_minus = 1'b1;
        // R6 uart level applied
        if (next_uart_level_on)
          next_ctrl.regulator_level = ctl[`UIOP_UART_HI:`UIOP_UART_LO];
      end
      UIOP_MODE_AUDIO:
      begin
        // R7 audio fixed 3.3V
        next_ctrl.regulator_level = `UIOP_LVL_3V30;
        // R5 speaker routing unswapped
        next_ctrl.data_pin_swap   = 1'b0;
      end
      default:
      begin
        next_ctrl.regulator_level = ctl[`UIOP_USB_HI:`UIOP_USB_LO];
      end
    endcase
  end

  // analog controls are registered so the front end never sees decode
  // glitches; the cost is one cycle of latency after a register write
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= '0;
    else
      ctrl <= next_ctrl;
  end

  // R4 R5 pad functions; the route block already applied the swap in uart
  // mode, and audio routing never depends on it
  assign data_plus_function  = ctrl.plus_route;
  assign data_minus_function = ctrl.minus_route;

endmodule

`default_nettype wire

// ===== src/uiop_defs.svh
`ifndef UIOP_DEFS_SVH
`define UIOP_DEFS_SVH

// register aliases (byte addresses on the register port)
`define UIOP_ADDR_BASE   8'h39
`define UIOP_ADDR_SET    8'h3a
`define UIOP_ADDR_CLEAR  8'h3b

// field positions
`define UIOP_BIT_SWAP    1
`define UIOP_UART_LO     2
`define UIOP_UART_HI     3
`define UIOP_BIT_PU_PLUS 4
`define UIOP_BIT_PU_MIN  5
`define UIOP_USB_LO      6
`define UIOP_USB_HI      7

// reset value: uart level 01, everything else zero; bit 0 always reads zero
`define UIOP_RESET_VAL   8'h04
`define UIOP_WRITE_MASK  8'hfe

// regulator level codes
`define UIOP_LVL_3V30    2'h0

// line routing selections
`define UIOP_ROUTE_USB   2'h0
`define UIOP_ROUTE_UART  2'h1
`define UIOP_ROUTE_UART_RX 2'h3
`define UIOP_ROUTE_AUDIO 2'h2

`endif

// ===== src/uiop_pkg.sv
package uiop_pkg;

  // operating mode of the transceiver as seen by this block
  typedef enum logic [1:0]
  {
    UIOP_MODE_USB   = 2'h0,
    UIOP_MODE_UART  = 2'h1,
    UIOP_MODE_AUDIO = 2'h2
  } uiop_mode_t;

  // register port request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uiop_req_t;

  // controls sent to the analog front end
  typedef struct packed
  {
    logic       data_pin_swap;
    logic       pullup_plus;
    logic       pullup_minus;
    logic [1:0] regulator_level;
    logic [1:0] plus_route;
    logic [1:0] minus_route;
  } uiop_ctrl_t;

endpackage

// ===== src/uiop_route.sv
`timescale 1ns/100ps
`default_nettype none
`include "uiop_defs.svh"

// picks what each usb data pad carries; audio routing ignores the swap
module uiop_route
  import uiop_pkg::*;
(
  input  wire uiop_mode_t mode,
  input  wire logic       swap,
  output logic [1:0]      plus_route,
  output logic [1:0]      minus_route
);

  // routing select per pad, combinational from the mode input and the registered swap bit
  always_comb
  begin
    plus_route  = `UIOP_ROUTE_USB;
    minus_route = `UIOP_ROUTE_USB;
    case (mode)
      // R4 swap exchanges transmit and receive pads
      UIOP_MODE_UART:
      begin
        plus_route  = swap ? `UIOP_ROUTE_UART_RX : `UIOP_ROUTE_UART;
        minus_route = swap ? `UIOP_ROUTE_UART : `UIOP_ROUTE_UART_RX;
      end
      UIOP_MODE_AUDIO:
      begin
        plus_route  = `UIOP_ROUTE_AUDIO;
        minus_route = `UIOP_ROUTE_AUDIO;
      end
      default:
      begin
        plus_route  = `UIOP_ROUTE_USB;
        minus_route = `UIOP_ROUTE_USB;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== tb/uiop_reg_sva.sv
`timescale 1ns/100ps
`default_nettype none
module uiop_reg_sva
  import uiop_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire uiop_req_t  req,
  input wire logic [7:0] rdata,
  input wire uiop_mode_t mode,
  input wire uiop_ctrl_t ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a swap write, then four quiet usb cycles so it surely reaches ctrl
  sequence s_set; req.wr && req.addr == 8'h3a && req.wdata[1]; endsequence
  sequence s_clr; req.wr && req.addr == 8'h3b && req.wdata[1]; endsequence
  sequence s_usb; (mode == UIOP_MODE_USB && !req.wr) [*4]; endsequence
  a_rd_idle: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("rdata");
  a_rd_bit0: assert property ($past(req.rd) |-> !rdata[0]) else $error("bit0");
  a_set_swap: assert property (s_set ##1 s_usb |-> ctrl.data_pin_swap) else $error("set");
  a_clr_swap: assert property (s_clr ##1 s_usb |-> !ctrl.data_pin_swap) else $error("clr");
  a_uart_pull: assert property ((mode == UIOP_MODE_UART) [*4] |->
    ctrl.pullup_plus && ctrl.pullup_minus) else $error("pull");
  a_audio_lvl: assert property ((mode == UIOP_MODE_AUDIO) [*4] |->
    ctrl.regulator_level == 2'h0) else $error("level");
  a_audio_swap: assert property ((mode == UIOP_MODE_AUDIO) [*4] |->
    !ctrl.data_pin_swap) else $error("swap");
  a_reset_lvl: assert property ($past(rst) |-> ctrl.regulator_level == 2'h0) else $error("rst");
endmodule
bind uiop_reg uiop_reg_sva i_uiop_reg_sva
  (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .mode(mode), .ctrl(ctrl));
`default_nettype wire

// ===== tb/uiop_link.sv
`timescale 1ns/100ps
`default_nettype none
module uiop_link
  import uiop_pkg::*;
(
  input  wire logic      clk,
  input  wire uiop_req_t cmd,
  input  wire logic      rst_req,
  output uiop_req_t      req,
  output logic           rst
);
  // link launches each cycle just after the edge
  always_ff @(posedge clk)
  begin
    req <= cmd;
    rst <= rst_req;
  end
endmodule
`default_nettype wire

// ===== tb/test_usb_io_power_mgmt_reg.sv
`timescale 1ns/100ps
`default_nettype none
module test_usb_io_power_mgmt_reg;
  import uiop_pkg::*;
  logic       clk = 1'b0, rst_req = 1'b1, rst, txe = 1'b0, rd_seen = 1'b0;
  logic [7:0] rdata, exp_reg, q[$];
  logic [1:0] dpf, dmf;
  uiop_req_t  cmd = '0, req;
  uiop_mode_t mode = UIOP_MODE_USB;
  uiop_ctrl_t ctrl;
  int         error_cnt = 0, num_checks = 0, cycles = 0, seed = 32'h26514821;
  uiop_link i_uiop_link (.clk(clk), .cmd(cmd), .rst_req(rst_req), .req(req), .rst(rst));
  uiop_reg i_uiop_reg (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .mode(mode),
    .uart_transmit_enable(txe), .ctrl(ctrl), .data_plus_function(dpf),
    .data_minus_function(dmf));
  always #5 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task results;
    $display("mismatches %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task bus(input uiop_req_t r);
    @(posedge clk);
    cmd <= r;
  endtask
  // model of the alias behaviour; bit 0 never sticks
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus('{a, d, 1'b1, 1'b0});
    exp_reg = a == 8'h39 ? d : a == 8'h3a ? exp_reg | d : exp_reg & ~d;
    exp_reg &= 8'hfe;
  endtask
  // three aliases then one unmapped address, back to back
  task rd3;
    for (int i = 0; i < 4; i++)
    begin
      q.push_back(i < 3 ? exp_reg : 8'h00);
      bus('{8'h39 + 8'(i), 8'h00, 1'b0, 1'b1});
    end
    bus('0);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    cycles++;
    if (rd_seen)
      chk(rdata, q.pop_front());
    rd_seen <= req.rd;
    if (cycles == 2000)
    begin
      error_cnt++;
      results;
    end
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_req <= 1'b0;
    exp_reg = 8'h04;
    repeat (2) @(posedge clk);
    rd3;
    for (int i = 0; i < 24; i++)
    begin
      wr(8'h39 + 8'(i % 3), 8'($random(seed)));
      rd3;
    end
    for (int i = 0; i < 60; i++)
    begin
      mode <= i % 3 == 0 ? UIOP_MODE_AUDIO : $random(seed) & 1 ? UIOP_MODE_UART : UIOP_MODE_USB;
      txe <= 1'($random(seed));
      wr(8'h3a + 8'(i % 2), 8'h02);
      bus('0);
      repeat (5) @(posedge clk);
    end
    mode <= UIOP_MODE_USB;
    txe <= 1'b0;
    wr(8'h39, 8'hf8);
    bus('0);
    repeat (5) @(posedge clk);
    chk({4'h0, ctrl.regulator_level, ctrl.pullup_plus, ctrl.pullup_minus}, 8'h0f);
    mode <= UIOP_MODE_UART;
    txe <= 1'b1;
    repeat (5) @(posedge clk);
    chk({6'h00, ctrl.regulator_level}, 8'h02);
    chk({4'h0, dpf, dmf}, 8'h07);
    wr(8'h3a, 8'h02);
    bus('0);
    repeat (5) @(posedge clk);
    chk({4'h0, dpf, dmf}, 8'h0d);
    mode <= UIOP_MODE_AUDIO;
    repeat (5) @(posedge clk);
    chk({6'h00, ctrl.regulator_level}, 8'h00);
    chk({4'h0, dpf, dmf}, 8'h0a);
    rst_req <= 1'b1;
    repeat (3) @(posedge clk);
    rst_req <= 1'b0;
    mode <= UIOP_MODE_USB;
    exp_reg = 8'h04;
    repeat (2) @(posedge clk);
    rd3;
    repeat (3) @(posedge clk);
    results;
  end
endmodule
`default_nettype wire
